// [src/amc_pkg.sv]
// package: pin bundles, density encoding and timing constants for the memory host controller
package amc_pkg;
  localparam int ADDR_W = 27;
  localparam int DATA_W = 32;
  localparam int CLK_PERIOD_PS = 5000;
  // access strobe width, least time, printed as the cycle time of the part
  localparam int ACCESS_NS = 45;
  localparam int ACCESS_CYC = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TURN_CYC = 2;
  localparam logic [7:0] ACCESS_CYC_8 = 8'(ACCESS_CYC);
  localparam logic [7:0] TURN_CYC_8 = 8'(TURN_CYC);
  // density codes: address width 25, 26, 27 bits, and two-bank form
  localparam logic [1:0] DENS_SMALL = 2'h0;
  localparam logic [1:0] DENS_MID = 2'h1;
  localparam logic [1:0] DENS_LARGE = 2'h2;
  localparam logic [1:0] DENS_BANKED = 2'h3;
  // ecc control register: bit 1 clears the uncorrectable-error interrupt
  localparam int ECC_INT_RST_BIT = 1;
  localparam logic [ADDR_W-1:0] ECC_CTRL_ADDR = 27'h0000000;
  localparam logic [DATA_W-1:0] ECC_INT_RST_WORD = 32'h00000002;

  typedef struct packed {
    logic write;
    logic cfg;
    logic page;
    logic bank;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } amc_req_t;

  typedef struct packed {
    logic bank0_select_n;
    logic bank1_select_n;
    logic out_en_n;
    logic wr_en_n;
    logic config_space_select_n;
    logic page_access_n;
  } amc_ctl_t;
endpackage : amc_pkg

// [src/amc_sync.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module amc_sync #(
  parameter int W = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  input wire logic [W-1:0] i_rst_val,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  // reset values are constants from the parent; i_rst_val is tied
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_ff <= '1;
      sync_ff <= '1;
    end else begin
      meta_ff <= i_d;
      sync_ff <= meta_ff;
    end
  end
  assign o_q = sync_ff ^ ~i_rst_val;
endmodule : amc_sync

// [src/amc_host.sv]
// host controller driving an asynchronous x32 persistent memory over its pins
`timescale 1ns/1ps
// Overview of operation
// - host never asserts both bank selects together.
// - write enable low writes host data; high reads memory data.
// - host holds unused upper address bits at zero on smaller parts.
// - one shared 32-bit bus carries data both ways, direction by enables.
// - interrupt stays latched until host writes a one to bit 1 of the ECC control register.
// - write drives select and write enable low; read drives select, output enable low.
// - writing one to ECC control bit 1 clears the interrupt; zero leaves it.
module amc_host (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // density strap, static while idle
  input wire logic [1:0] i_density,
  // request port
  input wire logic i_req_valid,
  input wire amc_pkg::amc_req_t i_req,
  input wire logic i_int_clear,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic [31:0] o_rsp_rdata,
  output logic o_int_pending,
  // memory pins
  output amc_pkg::amc_ctl_t o_mem_ctl,
  output logic [26:0] o_mem_addr,
  output logic [31:0] o_mem_dq_out,
  output logic o_mem_dq_oe,
  input wire logic [31:0] i_mem_dq_in,
  input wire logic i_mem_int_n
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WR = 4'h2,
    ST_RD = 4'h4,
    ST_TURN = 4'h8
  } amc_state_t;

  amc_state_t state_ff, nxt_state;
  logic [7:0] cnt_ff, nxt_cnt;
  amc_pkg::amc_ctl_t ctl_ff, nxt_ctl;
  logic [26:0] addr_ff;
  logic [31:0] wdata_ff;
  logic dq_oe_ff;
  logic rsp_valid_ff;
  logic [31:0] rdata_ff;
  logic [31:0] dq_sync;
  logic [0:0] int_n_sync;

  // width mask by density; unused upper bits forced low
  function automatic logic [26:0] amc_addr_mask(input logic [1:0] dens);
    unique case (dens)
      amc_pkg::DENS_SMALL: amc_addr_mask = 27'h1FFFFFF;
      amc_pkg::DENS_MID: amc_addr_mask = 27'h3FFFFFF;
      default: amc_addr_mask = 27'h7FFFFFF;
    endcase
  endfunction : amc_addr_mask

  // data bus sampled through two flops; read data is a settled level at strobe end
  amc_sync #(.W(32)) u_dq_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_d(i_mem_dq_in),
    .i_rst_val(32'hFFFFFFFF),
    .o_q(dq_sync)
  );
  amc_sync #(.W(1)) u_int_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_d(i_mem_int_n),
    .i_rst_val(1'h1),
    .o_q(int_n_sync)
  );

  wire start_w = (state_ff == ST_IDLE) && (i_req_valid || i_int_clear);
  // interrupt clear is an ecc control write with the reset bit set
  wire is_wr_w = i_int_clear || i_req.write;
  wire banked_w = (i_density == amc_pkg::DENS_BANKED);
  wire use_bank1_w = banked_w && !i_int_clear && i_req.bank;
  wire [26:0] req_addr_w = i_int_clear ? amc_pkg::ECC_CTRL_ADDR
                                       : (i_req.addr & amc_addr_mask(i_density));
  wire [31:0] req_wdata_w = i_int_clear ? amc_pkg::ECC_INT_RST_WORD : i_req.wdata;
  wire cnt_done_w = (cnt_ff == 8'h00);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_ctl = ctl_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (start_w) begin
          nxt_state = is_wr_w ? ST_WR : ST_RD;
          nxt_cnt = amc_pkg::ACCESS_CYC_8 - 8'h01;
          nxt_ctl.bank0_select_n = use_bank1_w;
          nxt_ctl.bank1_select_n = !use_bank1_w;
          nxt_ctl.wr_en_n = !is_wr_w;
          nxt_ctl.out_en_n = is_wr_w;
          nxt_ctl.config_space_select_n = !(i_int_clear || i_req.cfg);
          nxt_ctl.page_access_n = !(!i_int_clear && i_req.page);
        end
      end
      ST_WR, ST_RD: begin
        nxt_cnt = cnt_ff - 8'h01;
        if (cnt_done_w) begin
          nxt_state = ST_TURN;
          nxt_cnt = amc_pkg::TURN_CYC_8 - 8'h01;
          nxt_ctl = '1;
        end
      end
      ST_TURN: begin
        nxt_cnt = cnt_ff - 8'h01;
        if (cnt_done_w) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_ctl = '1;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 8'h00;
      ctl_ff <= '1;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      ctl_ff <= nxt_ctl;
    end
  end

  // address and write data held for the whole strobe
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      addr_ff <= 27'h0000000;
      wdata_ff <= 32'h00000000;
    end else if (start_w) begin
      addr_ff <= req_addr_w;
      wdata_ff <= req_wdata_w;
    end
  end

  // host drives dq only while writing, so it never fights the device output
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      dq_oe_ff <= 1'h0;
    end else begin
      dq_oe_ff <= (nxt_state == ST_WR);
    end
  end

  // read data captured at the end of the strobe; synchroniser delay is inside the strobe
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rsp_valid_ff <= 1'h0;
      rdata_ff <= 32'h00000000;
    end else begin
      rsp_valid_ff <= (state_ff == ST_WR || state_ff == ST_RD) && cnt_done_w;
      if (state_ff == ST_RD && cnt_done_w) begin
        rdata_ff <= dq_sync;
      end
    end
  end

  assign o_req_ready = (state_ff == ST_IDLE) && !i_int_clear;
  assign o_rsp_valid = rsp_valid_ff;
  assign o_rsp_rdata = rdata_ff;
  assign o_int_pending = !int_n_sync[0];
  assign o_mem_ctl = ctl_ff;
  assign o_mem_addr = addr_ff;
  assign o_mem_dq_out = wdata_ff;
  assign o_mem_dq_oe = dq_oe_ff;

  // both bank selects never low together
  bank_excl_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_mem_ctl.bank0_select_n || o_mem_ctl.bank1_select_n)
    else $error("both bank selects asserted");
  // host drive only with write enable low and output enable high
  dq_dir_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_mem_dq_oe |-> (!o_mem_ctl.wr_en_n && o_mem_ctl.out_en_n))
    else $error("host drives dq outside a write");
  // read strobe has select and output enable low, write enable high
  rd_strobe_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !o_mem_ctl.out_en_n |-> (o_mem_ctl.wr_en_n
      && !(o_mem_ctl.bank0_select_n && o_mem_ctl.bank1_select_n)))
    else $error("read strobe malformed");
  // write strobe has a select low
  wr_strobe_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !o_mem_ctl.wr_en_n |-> !(o_mem_ctl.bank0_select_n && o_mem_ctl.bank1_select_n))
    else $error("write strobe without select");
  // unused upper address bits stay zero during a read on the small part
  addr_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_ff == ST_RD && i_density == amc_pkg::DENS_SMALL) |-> o_mem_addr[26:25] == 2'h0)
    else $error("upper address not zero");
  // an interrupt clear becomes a write of bit 1 to the control register
  int_clr_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_ff == ST_IDLE && i_int_clear) |=> (!o_mem_ctl.wr_en_n
      && !o_mem_ctl.config_space_select_n && o_mem_dq_out[amc_pkg::ECC_INT_RST_BIT]))
    else $error("interrupt clear not issued");
  // response follows the start of an access after the strobe length
  rsp_time_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    start_w |-> ##10 o_rsp_valid)
    else $error("response not on time");
endmodule : amc_host

// [test/amc_mem_model.sv]
// behavioural model of the x32 persistent memory pins
`timescale 1ns/1ps
module amc_mem_model (
  // host pins
  input wire amc_pkg::amc_ctl_t i_ctl,
  input wire logic [26:0] i_addr,
  input wire logic [31:0] i_dq,
  input wire logic i_ecc_fail,
  // device drive
  output logic [31:0] o_dq,
  output logic o_dq_oe,
  output logic o_int_oe
);
  logic [31:0] mem [logic [28:0]];
  logic [28:0] key;
  logic [31:0] wbuf;
  wire sel = !i_ctl.bank0_select_n || !i_ctl.bank1_select_n;
  // page select accepted, data path stays single word
  wire [28:0] rkey = {!i_ctl.config_space_select_n, !i_ctl.bank1_select_n, i_addr};
  assign o_dq_oe = sel && !i_ctl.out_en_n && i_ctl.wr_en_n;
  // config space reads back reserved zeros
  assign o_dq = rkey[28] ? 32'h00000000 : mem[rkey];
  initial o_int_oe = 1'b0;
  // sample 3 ns after write enable falls so the host's own launch edge never races us
  always @(negedge i_ctl.wr_en_n) begin
    #3;
    wbuf = i_dq;
    key = rkey;
  end
  always @(posedge i_ctl.wr_en_n) begin
    if (key[28] && key[26:0] == amc_pkg::ECC_CTRL_ADDR && wbuf[1]) o_int_oe = 1'b0;
    else if (!key[28]) mem[key] = wbuf;
  end
  // read the select fields here, not sel, which may settle after this event
  always @(negedge i_ctl.out_en_n) begin
    if ((!i_ctl.bank0_select_n || !i_ctl.bank1_select_n) && i_ecc_fail) begin
      o_int_oe = 1'b1;
    end
  end
endmodule : amc_mem_model

// [test/amc_host_bench.sv]
// self-checking bench for the memory host controller
`timescale 1ns/1ps
module amc_host_bench;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [1:0] i_density = 2'h0;
  logic i_req_valid = 1'b0;
  amc_pkg::amc_req_t i_req = '0;
  logic i_int_clear = 1'b0;
  logic ecc_fail = 1'b0;
  logic o_req_ready, o_rsp_valid, o_int_pending, o_mem_dq_oe, dev_oe, int_oe;
  logic [31:0] o_rsp_rdata, o_mem_dq_out, dev_dq, rd;
  logic [31:0] dq_last = 32'h00000000;
  amc_pkg::amc_ctl_t o_mem_ctl;
  logic [26:0] o_mem_addr;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  // a released bus shows no stale data
  wire [31:0] dq = o_mem_dq_oe ? o_mem_dq_out : dev_oe ? dev_dq : ~dq_last;
  wire int_n = !int_oe;
  amc_host uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_density(i_density),
    .i_req_valid(i_req_valid), .i_req(i_req), .i_int_clear(i_int_clear),
    .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata),
    .o_int_pending(o_int_pending), .o_mem_ctl(o_mem_ctl), .o_mem_addr(o_mem_addr),
    .o_mem_dq_out(o_mem_dq_out), .o_mem_dq_oe(o_mem_dq_oe), .i_mem_dq_in(dq),
    .i_mem_int_n(int_n));
  amc_mem_model model (.i_ctl(o_mem_ctl), .i_addr(o_mem_addr), .i_dq(dq),
    .i_ecc_fail(ecc_fail), .o_dq(dev_dq), .o_dq_oe(dev_oe), .o_int_oe(int_oe));
  initial forever #2.5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) if (o_mem_dq_oe || dev_oe) dq_last <= dq;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  task automatic access(input logic clr, input amc_pkg::amc_req_t r);
    int n;
    logic b;
    logic [26:0] m;
    b = (i_density == amc_pkg::DENS_BANKED) && r.bank;
    m = i_density[1] ? 27'h7FFFFFF : 27'h7FFFFFF >> (2'h2 - i_density);
    i_req = r;
    i_int_clear = clr;
    i_req_valid = !clr;
    #1 check(32'(o_req_ready), 32'(!clr));
    @(posedge i_ref_clk);
    #1 i_req_valid = 1'b0;
    i_int_clear = 1'b0;
    repeat (5) @(posedge i_ref_clk);
    #1 if (!clr) check(32'(o_mem_ctl), 32'({b, !b, r.write, !r.write, !r.cfg, !r.page}));
    if (!clr) check(32'(o_mem_addr), 32'(r.addr & m));
    check(32'(o_req_ready), 32'h00000000);
    n = 5;
    do begin
      @(posedge i_ref_clk);
      #1 n++;
    end while (o_rsp_valid !== 1'b1 && n < 20);
    check(32'(n), 32'(amc_pkg::ACCESS_CYC));
    rd = o_rsp_rdata;
    repeat (2) @(posedge i_ref_clk);
    #1;
  endtask : access
  task automatic rw_densities();
    amc_pkg::amc_req_t r;
    for (int d = 0; d < 3; d++) begin
      i_density = 2'(d);
      r = '{write: 1'b1, cfg: 1'b0, page: 1'b0, bank: 1'b1, addr: 27'h7FFFFFF, wdata: 32'h5A00A500 + d};
      access(1'b0, r);
      r.write = 1'b0;
      access(1'b0, r);
      check(rd, 32'h5A00A500 + d);
    end
  endtask : rw_densities
  task automatic two_banks();
    amc_pkg::amc_req_t r;
    i_density = amc_pkg::DENS_BANKED;
    r = '{write: 1'b1, cfg: 1'b0, page: 1'b1, bank: 1'b0, addr: 27'h0000005, wdata: 32'h11111111};
    access(1'b0, r);
    r.bank = 1'b1;
    r.wdata = 32'hEEEEEEEE;
    access(1'b0, r);
    r.write = 1'b0;
    access(1'b0, r);
    check(rd, 32'hEEEEEEEE);
    r.bank = 1'b0;
    access(1'b0, r);
    check(rd, 32'h11111111);
  endtask : two_banks
  task automatic ecc_interrupt();
    amc_pkg::amc_req_t r;
    r = '{write: 1'b0, cfg: 1'b0, page: 1'b0, bank: 1'b0, addr: 27'h0000005, wdata: 32'h0};
    ecc_fail = 1'b1;
    access(1'b0, r);
    ecc_fail = 1'b0;
    check(32'(o_int_pending), 32'h1);
    r = '{write: 1'b1, cfg: 1'b1, page: 1'b0, bank: 1'b0, addr: amc_pkg::ECC_CTRL_ADDR, wdata: 32'h1};
    access(1'b0, r);
    repeat (4) @(posedge i_ref_clk);
    #1 check(32'(o_int_pending), 32'h1);
    access(1'b1, r);
    repeat (4) @(posedge i_ref_clk);
    #1 check(32'(o_int_pending), 32'h0);
  endtask : ecc_interrupt
  always @(negedge i_ref_clk) if (!i_rst) begin
    cyc++;
    if (!o_mem_ctl.bank0_select_n && !o_mem_ctl.bank1_select_n) check(32'h1, 32'h0);
    if (o_mem_dq_oe && dev_oe) check(32'h2, 32'h0);
    if (!i_density[1]) check(32'(o_mem_addr >> (25 + int'(i_density))), 32'h0);
    if (i_density != amc_pkg::DENS_BANKED) check(32'(o_mem_ctl.bank1_select_n), 32'h1);
    if (cyc > 2000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    repeat (3) @(posedge i_ref_clk);
    #1 i_rst = 1'b0;
    rw_densities();
    two_banks();
    ecc_interrupt();
    complete_run();
  end
endmodule : amc_host_bench
